// ### rtl/txlo_top.sv
// Transmit launch decision and transmit outcome status
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - A frame starts once its loaded word count exceeds the launch level or the whole frame is loaded.
// - Any checksum offload enable makes the block wait for the whole frame instead.
// - The outcome word at 0x60 is 32 bits, resets to zero and clears when read.
// - Bit 0 is set whenever the late, excess or starvation flag is set.
// - Bit 2 is set when a collision comes after 4,096 bit times.
// - After a late collision the frame stays in the FIFO and is sent again on re-enable, unless the FIFO was cleared first.
// - Bit 3 is set when a frame fails on its 16th collision.
// - On excess collisions the frame is dropped from the FIFO.
// - On starvation bit 4 is set and transmitter and FIFO halt.
// - Bit 6 is set when the descriptor asked for a notify.
// - Every attempt rewrites the whole word and sets bit 7.
// - Bits 31 to 16 carry the tag of the reported frame.
module txlo_top
    import txlo_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    input wire logic DESC_VALID,
    input wire txlo_desc_ctrl_s DESC_CTRL,
    input wire logic [15:0] FIFO_WORDS,
    input wire logic FIFO_FRAME_LOADED,
    input wire logic LINK_BIT_TICK,
    input wire logic LINK_COLLISION,
    input wire logic LINK_FRAME_END,
    input wire logic FIFO_STARVED,
    input wire logic TRANSMITTER_ON_SET,
    input wire logic TRANSMITTER_REINIT,
    input wire logic FIFO_CLEAR,
    output logic TX_LAUNCH,
    output logic FRAME_RELEASE,
    output logic FRAME_DISCARD,
    output logic TX_HALTED,
    output logic FIFO_HALTED
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    txlo_state_e state_q, state_d;
    logic [TXLO_LAUNCH_W-1:0] launch_q, launch_d;
    txlo_desc_ctrl_s ctrl_q, ctrl_d;
    logic have_desc_q, have_desc_d;
    logic cleared_q, cleared_d;
    logic reinit_seen_q, reinit_seen_d;
    logic launch_o_q, launch_o_d;
    logic release_q, release_d;
    logic discard_q, discard_d;
    logic halt_q, halt_d;
    logic fifo_halt_q, fifo_halt_d;
    logic [31:0] rdata_q, rdata_d;
    logic out_upd;
    txlo_outcome_s out_new;
    txlo_outcome_s out_word;
    logic late_p;
    logic excess_p;
    logic sending;
    logic rd_outcome;
    logic launch_ok;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Offload needs the full frame for the checksum pass
    function automatic logic txlo_offload(input txlo_desc_ctrl_s c);
        txlo_offload = c.ipv4_sum_offload_enable | c.tcp_sum_offload_enable | c.udp_sum_offload_enable;
    endfunction

    function automatic logic txlo_hit(input logic [7:0] a, input logic [7:0] ofs);
        txlo_hit = (a == ofs);
    endfunction

    assign sending = (state_q == TXLO_SEND);
    assign rd_outcome = REG_RD && txlo_hit(REG_ADDR, TXLO_OFS_OUTCOME);

    // Launch gate: whole frame under offload, else whole frame or word count above the level
    always_comb begin
        if (txlo_offload(ctrl_q)) begin
            launch_ok = FIFO_FRAME_LOADED;
        end else begin
            launch_ok = FIFO_FRAME_LOADED || (FIFO_WORDS > {4'h0, launch_q});
        end
    end

    // ------------------------------------------------------------
    // Collision tracking and outcome storage
    // ------------------------------------------------------------
    txlo_coll_track u_coll (
        .clk(CLK),
        .rst(RST),
        .active(sending),
        .bit_tick(LINK_BIT_TICK),
        .collision(LINK_COLLISION),
        .late_pulse(late_p),
        .excess_pulse(excess_p)
    );

    txlo_outcome_reg u_outcome (
        .clk(CLK),
        .rst(RST),
        .update(out_upd),
        .update_word(out_new),
        .read_clear(rd_outcome),
        .word(out_word)
    );

    // ------------------------------------------------------------
    // Attempt outcome assembly
    // ------------------------------------------------------------
    // Priority: late collision, then excess, then starvation, then success
    always_comb begin
        out_new = TXLO_OUTCOME_RST;
        out_upd = 1'b0;
        if (sending) begin
            if (late_p) begin
                out_new.post_slot_collision_flag = 1'b1;
                out_upd = 1'b1;
            end else if (excess_p) begin
                out_new.excess_retry_flag = 1'b1;
                out_upd = 1'b1;
            end else if (FIFO_STARVED) begin
                out_new.send_starvation_flag = 1'b1;
                out_upd = 1'b1;
            end else if (LINK_FRAME_END) begin
                out_upd = 1'b1;
            end
        end
        out_new.send_fault_summary = out_new.post_slot_collision_flag | out_new.excess_retry_flag
            | out_new.send_starvation_flag;
        out_new.notify_requested_flag = ctrl_q.notify_request_bit;
        out_new.send_done_flag = out_upd;
        out_new.reported_frame_tag = ctrl_q.frame_tag;
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Upper bits of the launch level are dropped; they read as zero
    always_comb begin
        launch_d = launch_q;
        rdata_d = rdata_q;
        if (REG_WR && txlo_hit(REG_ADDR, TXLO_OFS_LAUNCH)) begin
            launch_d = REG_WDATA[TXLO_LAUNCH_W-1:0];
        end
        if (REG_RD) begin
            if (rd_outcome) begin
                rdata_d = out_word;
            end else if (txlo_hit(REG_ADDR, TXLO_OFS_LAUNCH)) begin
                rdata_d = {20'h00000, launch_q};
            end else begin
                rdata_d = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            launch_q <= TXLO_LAUNCH_RST;
            rdata_q <= 32'h0000_0000;
        end else begin
            launch_q <= launch_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Launch and recovery state machine
    // ------------------------------------------------------------
    // Descriptor control is caught at fetch and held for the whole attempt
    always_comb begin
        state_d = state_q;
        ctrl_d = ctrl_q;
        have_desc_d = have_desc_q;
        cleared_d = cleared_q;
        reinit_seen_d = reinit_seen_q;
        launch_o_d = 1'b0;
        release_d = 1'b0;
        discard_d = 1'b0;
        halt_d = halt_q;
        fifo_halt_d = fifo_halt_q;
        unique case (state_q)
            TXLO_IDLE: begin
                if (DESC_VALID) begin
                    ctrl_d = DESC_CTRL;
                    have_desc_d = 1'b1;
                    state_d = TXLO_WAIT_LOAD;
                end
            end
            TXLO_WAIT_LOAD: begin
                if (launch_ok) begin
                    state_d = TXLO_SEND;
                    launch_o_d = 1'b1;
                end
            end
            TXLO_SEND: begin
                launch_o_d = 1'b1;
                if (late_p) begin
                    launch_o_d = 1'b0;
                    halt_d = 1'b1;
                    cleared_d = 1'b0;
                    state_d = TXLO_HOLD_LATE;
                end else if (excess_p) begin
                    launch_o_d = 1'b0;
                    halt_d = 1'b1;
                    discard_d = 1'b1;
                    state_d = TXLO_HOLD_EXCESS;
                end else if (FIFO_STARVED) begin
                    launch_o_d = 1'b0;
                    halt_d = 1'b1;
                    fifo_halt_d = 1'b1;
                    reinit_seen_d = 1'b0;
                    state_d = TXLO_HOLD_STARVE;
                end else if (LINK_FRAME_END) begin
                    launch_o_d = 1'b0;
                    release_d = 1'b1;
                    have_desc_d = 1'b0;
                    state_d = TXLO_IDLE;
                end
            end
            TXLO_HOLD_LATE: begin
                // Frame stays queued unless software flushes the FIFO first
                if (FIFO_CLEAR) begin
                    cleared_d = 1'b1;
                end
                if (TRANSMITTER_ON_SET) begin
                    halt_d = 1'b0;
                    if (cleared_q || FIFO_CLEAR) begin
                        discard_d = 1'b1;
                        have_desc_d = 1'b0;
                        state_d = TXLO_IDLE;
                    end else begin
                        state_d = TXLO_WAIT_LOAD;
                    end
                end
            end
            TXLO_HOLD_EXCESS: begin
                if (TRANSMITTER_ON_SET) begin
                    halt_d = 1'b0;
                    have_desc_d = 1'b0;
                    state_d = TXLO_IDLE;
                end
            end
            TXLO_HOLD_STARVE: begin
                // Both controls must be seen, reinit first or together; an on set before reinit is not kept
                if (TRANSMITTER_REINIT) begin
                    reinit_seen_d = 1'b1;
                end
                if (TRANSMITTER_ON_SET && (reinit_seen_q || TRANSMITTER_REINIT)) begin
                    halt_d = 1'b0;
                    fifo_halt_d = 1'b0;
                    discard_d = 1'b1;
                    have_desc_d = 1'b0;
                    state_d = TXLO_IDLE;
                end
            end
            default: begin
                state_d = TXLO_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= TXLO_IDLE;
            ctrl_q <= '0;
            have_desc_q <= 1'b0;
            cleared_q <= 1'b0;
            reinit_seen_q <= 1'b0;
            launch_o_q <= 1'b0;
            release_q <= 1'b0;
            discard_q <= 1'b0;
            halt_q <= 1'b0;
            fifo_halt_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ctrl_q <= ctrl_d;
            have_desc_q <= have_desc_d;
            cleared_q <= cleared_d;
            reinit_seen_q <= reinit_seen_d;
            launch_o_q <= launch_o_d;
            release_q <= release_d;
            discard_q <= discard_d;
            halt_q <= halt_d;
            fifo_halt_q <= fifo_halt_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign REG_RDATA = rdata_q;
    assign TX_LAUNCH = launch_o_q;
    assign FRAME_RELEASE = release_q;
    assign FRAME_DISCARD = discard_q;
    assign TX_HALTED = halt_q;
    assign FIFO_HALTED = fifo_halt_q;
endmodule
`default_nettype wire

// ### shared/txlo_pkg.sv
// Package for the transmit launch and outcome status block
package txlo_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] TXLO_OFS_OUTCOME = 8'h60;
    localparam logic [7:0] TXLO_OFS_LAUNCH = 8'h3c;
    localparam logic [31:0] TXLO_OUTCOME_RST = 32'h0000_0000;
    localparam logic [11:0] TXLO_LAUNCH_RST = 12'h000;
    localparam int TXLO_LAUNCH_W = 12;
    localparam int TXLO_WCNT_W = 16;

    // ------------------------------------------------------------
    // Collision timing in bit times, and the collision limit
    // ------------------------------------------------------------
    localparam logic [12:0] TXLO_SLOT_BITS = 13'h1000;
    localparam logic [4:0] TXLO_MAX_COLL = 5'h10;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic ipv4_sum_offload_enable;
        logic tcp_sum_offload_enable;
        logic udp_sum_offload_enable;
        logic notify_request_bit;
        logic [15:0] frame_tag;
    } txlo_desc_ctrl_s;

    typedef struct packed {
        logic [15:0] reported_frame_tag;
        logic [7:0] rsvd_hi;
        logic send_done_flag;
        logic notify_requested_flag;
        logic rsvd_5;
        logic send_starvation_flag;
        logic excess_retry_flag;
        logic post_slot_collision_flag;
        logic rsvd_1;
        logic send_fault_summary;
    } txlo_outcome_s;

    typedef enum logic [2:0] {
        TXLO_IDLE = 3'b000,
        TXLO_WAIT_LOAD = 3'b001,
        TXLO_SEND = 3'b010,
        TXLO_HOLD_LATE = 3'b011,
        TXLO_HOLD_EXCESS = 3'b100,
        TXLO_HOLD_STARVE = 3'b101
    } txlo_state_e;

endpackage

// ### rtl/txlo_coll_track.sv
// Collision tracker: slot time and collision count for one frame
`timescale 1ns/100ps
`default_nettype none
module txlo_coll_track
    import txlo_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic active,
    input wire logic bit_tick,
    input wire logic collision,
    output logic late_pulse,
    output logic excess_pulse
);
    logic [12:0] bits_q, bits_d;
    logic [4:0] coll_q, coll_d;
    logic late_q, late_d;
    logic excess_q, excess_d;

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    // Bit counter saturates at the slot time so it never wraps on jumbo frames
    always_comb begin
        bits_d = bits_q;
        coll_d = coll_q;
        late_d = 1'b0;
        excess_d = 1'b0;
        if (!active) begin
            bits_d = '0;
            coll_d = '0;
        end else begin
            if (bit_tick && bits_q < TXLO_SLOT_BITS) begin
                bits_d = bits_q + 13'h0001;
            end
            if (collision) begin
                if (bits_q >= TXLO_SLOT_BITS) begin
                    late_d = 1'b1;
                end else if (coll_q == TXLO_MAX_COLL - 5'h01) begin
                    excess_d = 1'b1;
                    coll_d = TXLO_MAX_COLL;
                end else begin
                    coll_d = coll_q + 5'h01;
                    bits_d = '0; // Retry restarts the slot window
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bits_q <= '0;
            coll_q <= '0;
            late_q <= 1'b0;
            excess_q <= 1'b0;
        end else begin
            bits_q <= bits_d;
            coll_q <= coll_d;
            late_q <= late_d;
            excess_q <= excess_d;
        end
    end

    assign late_pulse = late_q;
    assign excess_pulse = excess_q;
endmodule
`default_nettype wire

// ### rtl/txlo_outcome_reg.sv
// Clear-on-read transmit outcome word
`timescale 1ns/100ps
`default_nettype none
module txlo_outcome_reg
    import txlo_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic update,
    input wire txlo_outcome_s update_word,
    input wire logic read_clear,
    output txlo_outcome_s word
);
    txlo_outcome_s word_q, word_d;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // A fresh outcome beats the read clear so no attempt result is lost
    always_comb begin
        word_d = word_q;
        if (update) begin
            word_d = update_word;
        end else if (read_clear) begin
            word_d = TXLO_OUTCOME_RST;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            word_q <= TXLO_OUTCOME_RST;
        end else begin
            word_q <= word_d;
        end
    end

    assign word = word_q;
endmodule
`default_nettype wire

// ### dv/txlo_link_model.sv
// Network-side partner model: bit ticks, collisions and frame end
`timescale 1ns/100ps
`default_nettype none
module txlo_link_model (
    input wire logic sending,
    input wire logic coll_cmd,
    input wire logic end_cmd,
    output logic bit_tick,
    output logic collision,
    output logic frame_end
);
    // One bit time per cycle while a frame is on the wire, quiet line otherwise
    assign bit_tick = sending;
    // Events only land on a live frame, as on a real segment
    assign collision = coll_cmd & sending;
    assign frame_end = end_cmd & sending;
endmodule
`default_nettype wire

// ### dv/txlo_top_sva.sv
// Port checker for the transmit launch and outcome status block
`timescale 1ns/100ps
`default_nettype none
module txlo_top_sva
    import txlo_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_RD,
    input wire logic REG_WR,
    input wire logic [31:0] REG_WDATA,
    input wire logic [31:0] REG_RDATA,
    input wire logic [15:0] FIFO_WORDS,
    input wire logic FIFO_FRAME_LOADED,
    input wire logic LINK_COLLISION,
    input wire logic LINK_FRAME_END,
    input wire logic FIFO_STARVED,
    input wire logic TX_LAUNCH,
    input wire logic FRAME_RELEASE,
    input wire logic FRAME_DISCARD,
    input wire logic TX_HALTED,
    input wire logic FIFO_HALTED
);
    logic launch_q, fresh_q, cleared_q, fell, rd60, above;
    logic [TXLO_LAUNCH_W-1:0] lvl_q;
    assign fell = launch_q & ~TX_LAUNCH;
    // Mirror of the launch level so the threshold itself is checked
    assign above = FIFO_WORDS > {4'h0, lvl_q};
    assign rd60 = REG_RD && REG_ADDR == TXLO_OFS_OUTCOME;
    // Word news tracking; any live send may update, so it voids the cleared mark
    always_ff @(posedge CLK) begin
        if (RST) begin
            launch_q <= 1'b0;
            fresh_q <= 1'b0;
            cleared_q <= 1'b1;
            lvl_q <= TXLO_LAUNCH_RST;
        end else begin
            launch_q <= TX_LAUNCH;
            fresh_q <= rd60 ? 1'b0 : (fresh_q | fell);
            cleared_q <= TX_LAUNCH ? 1'b0 : (rd60 ? 1'b1 : cleared_q);
            if (REG_WR && REG_ADDR == TXLO_OFS_LAUNCH) begin
                lvl_q <= REG_WDATA[TXLO_LAUNCH_W-1:0];
            end
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_rd60;
        REG_RD && REG_ADDR == TXLO_OFS_OUTCOME;
    endsequence
    sequence s_clean_end;
        TX_LAUNCH && LINK_FRAME_END && !LINK_COLLISION && !$past(LINK_COLLISION) && !FIFO_STARVED;
    endsequence
    property p_clr_read;
        s_rd60 ##0 (cleared_q && !TX_LAUNCH) |=> REG_RDATA == 32'h0000_0000;
    endproperty
    property p_done;
        s_rd60 ##0 (fresh_q | fell) |=> REG_RDATA[7] && (REG_RDATA[0] == |REG_RDATA[4:2]);
    endproperty
    property p_starve_bit;
        s_rd60 ##0 ((fresh_q | fell) && FIFO_HALTED) |=> REG_RDATA[4];
    endproperty
    property p_launch_cause;
        $rose(TX_LAUNCH) |-> $past(FIFO_FRAME_LOADED) || $past(above);
    endproperty
    property p_release;
        FRAME_RELEASE |-> $fell(TX_LAUNCH) ##1 !FRAME_RELEASE;
    endproperty
    property p_end;
        s_clean_end |=> FRAME_RELEASE && !TX_LAUNCH;
    endproperty
    property p_discard;
        FRAME_DISCARD |-> !TX_LAUNCH;
    endproperty
    property p_halted;
        TX_HALTED |-> !TX_LAUNCH;
    endproperty
    property p_fifo_halt;
        FIFO_HALTED |-> TX_HALTED;
    endproperty
    property p_starve;
        TX_LAUNCH && FIFO_STARVED && !LINK_COLLISION && !$past(LINK_COLLISION) |=> FIFO_HALTED && TX_HALTED;
    endproperty
    a_clr_read: assert property (p_clr_read) else $error("outcome not cleared by read");
    a_done: assert property (p_done) else $error("done or summary bit wrong");
    a_starve_bit: assert property (p_starve_bit) else $error("starvation bit missing");
    a_launch_cause: assert property (p_launch_cause) else $error("launch at or below level");
    a_release: assert property (p_release) else $error("release without launch drop");
    a_end: assert property (p_end) else $error("frame end not released");
    a_discard: assert property (p_discard) else $error("discard while sending");
    a_halted: assert property (p_halted) else $error("sending while halted");
    a_fifo_halt: assert property (p_fifo_halt) else $error("fifo halt without tx halt");
    a_starve: assert property (p_starve) else $error("starvation did not halt");
endmodule
bind txlo_top txlo_top_sva u_sva (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
    .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .FIFO_WORDS(FIFO_WORDS), .FIFO_FRAME_LOADED(FIFO_FRAME_LOADED),
    .LINK_COLLISION(LINK_COLLISION), .LINK_FRAME_END(LINK_FRAME_END), .FIFO_STARVED(FIFO_STARVED),
    .TX_LAUNCH(TX_LAUNCH), .FRAME_RELEASE(FRAME_RELEASE), .FRAME_DISCARD(FRAME_DISCARD),
    .TX_HALTED(TX_HALTED), .FIFO_HALTED(FIFO_HALTED));
`default_nettype wire

// ### dv/test_tx_launch_and_outcome_status.sv
// Testbench for the transmit launch and outcome status block
`timescale 1ns/100ps
`default_nettype none
module test_tx_launch_and_outcome_status;
    import txlo_pkg::*;
    localparam logic [6:0] C_COLL = 7'h40, C_END = 7'h20, C_STARVE = 7'h10, C_ON = 7'h08;
    localparam logic [6:0] C_REINIT = 7'h04, C_CLR = 7'h02, C_DESC = 7'h01;
    logic CLK, RST, REG_WR, REG_RD, DESC_VALID, FIFO_FRAME_LOADED, FIFO_STARVED, coll_cmd, end_cmd;
    logic TRANSMITTER_ON_SET, TRANSMITTER_REINIT, FIFO_CLEAR, LINK_BIT_TICK, LINK_COLLISION, LINK_FRAME_END;
    logic TX_LAUNCH, FRAME_RELEASE, FRAME_DISCARD, TX_HALTED, FIFO_HALTED;
    logic [7:0] REG_ADDR;
    logic [31:0] REG_WDATA, REG_RDATA, rdata;
    logic [15:0] FIFO_WORDS;
    logic [4:0] obs;
    txlo_desc_ctrl_s DESC_CTRL;
    int errors, cmp_count;
    assign obs = {TX_LAUNCH, FRAME_RELEASE, FRAME_DISCARD, TX_HALTED, FIFO_HALTED};
    txlo_top uut (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .DESC_VALID(DESC_VALID), .DESC_CTRL(DESC_CTRL),
        .FIFO_WORDS(FIFO_WORDS), .FIFO_FRAME_LOADED(FIFO_FRAME_LOADED), .LINK_BIT_TICK(LINK_BIT_TICK),
        .LINK_COLLISION(LINK_COLLISION), .LINK_FRAME_END(LINK_FRAME_END), .FIFO_STARVED(FIFO_STARVED),
        .TRANSMITTER_ON_SET(TRANSMITTER_ON_SET), .TRANSMITTER_REINIT(TRANSMITTER_REINIT),
        .FIFO_CLEAR(FIFO_CLEAR), .TX_LAUNCH(TX_LAUNCH), .FRAME_RELEASE(FRAME_RELEASE),
        .FRAME_DISCARD(FRAME_DISCARD), .TX_HALTED(TX_HALTED), .FIFO_HALTED(FIFO_HALTED));
    txlo_link_model u_link (.sending(TX_LAUNCH), .coll_cmd(coll_cmd), .end_cmd(end_cmd),
        .bit_tick(LINK_BIT_TICK), .collision(LINK_COLLISION), .frame_end(LINK_FRAME_END));
    // ----------------------------------------
    // Shared drivers and comparison
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge CLK);
        REG_ADDR = a;
        REG_RD = 1'b1;
        @(negedge CLK);
        REG_RD = 1'b0;
        rdata = REG_RDATA;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge CLK);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        @(negedge CLK);
        REG_WR = 1'b0;
    endtask
    // One-cycle command strobes; a low cycle always follows, so strobes never merge
    task automatic pulse(input logic [6:0] m);
        @(negedge CLK);
        {coll_cmd, end_cmd, FIFO_STARVED, TRANSMITTER_ON_SET, TRANSMITTER_REINIT, FIFO_CLEAR, DESC_VALID} = m;
        @(negedge CLK);
        {coll_cmd, end_cmd, FIFO_STARVED, TRANSMITTER_ON_SET, TRANSMITTER_REINIT, FIFO_CLEAR, DESC_VALID} = 7'h00;
    endtask
    // Bounded wait for one observed output to go high
    task automatic await(input int b, input string what);
        for (int i = 0; i < 8 && obs[b] !== 1'b1; i++) @(negedge CLK);
        chk(obs[b], 1'b1, what);
    endtask
    task automatic start(input logic [19:0] c);
        FIFO_WORDS = 16'h0040;
        DESC_CTRL = c;
        pulse(C_DESC);
    endtask
    task automatic finish_ok(input logic [31:0] exp);
        pulse(C_END);
        await(3, "release");
        chk(TX_LAUNCH, 1'b0, "launch drops");
        rd(TXLO_OFS_OUTCOME);
        chk(rdata, exp, "outcome word");
        rd(TXLO_OFS_OUTCOME);
        chk(rdata, 32'h0000_0000, "read clears");
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        rd(TXLO_OFS_OUTCOME);
        chk(rdata, TXLO_OUTCOME_RST, "outcome reset");
        rd(TXLO_OFS_LAUNCH);
        chk(rdata, 32'h0000_0000, "level reset");
        wr(TXLO_OFS_LAUNCH, 32'h0000_0abc);
        rd(TXLO_OFS_LAUNCH);
        chk(rdata, 32'h0000_0abc, "level readback");
        rd(8'h10);
        chk(rdata, 32'h0000_0000, "unmapped read");
    endtask
    // Level 5: five words must not start the frame, the sixth must
    task automatic t_thresh;
        wr(TXLO_OFS_LAUNCH, 32'h0000_0005);
        start(20'h1_1234);
        FIFO_WORDS = 16'h0005;
        repeat (10) @(negedge CLK);
        chk(TX_LAUNCH, 1'b0, "launch at level");
        DESC_CTRL = 20'h0_5555;
        pulse(C_DESC);
        FIFO_WORDS = 16'h0006;
        await(4, "launch above level");
        finish_ok(32'h1234_00c0);
    endtask
    task automatic t_offload;
        for (int k = 0; k < 3; k++) begin
            start({3'b100 >> k, 1'b0, 16'h0a00 + k[15:0]});
            repeat (10) @(negedge CLK);
            chk(TX_LAUNCH, 1'b0, "offload waits");
            FIFO_FRAME_LOADED = 1'b1;
            await(4, "offload launch");
            finish_ok({16'h0a00 + k[15:0], 16'h0080});
            FIFO_FRAME_LOADED = 1'b0;
        end
    endtask
    // Collision after the slot time; resend, or drop when software clears first
    task automatic t_late(input logic clear);
        start(20'h0_0c0e);
        await(4, "launch");
        repeat (4100) @(negedge CLK);
        pulse(C_COLL);
        await(1, "late halt");
        chk(TX_LAUNCH, 1'b0, "late stops send");
        rd(TXLO_OFS_OUTCOME);
        chk(rdata, 32'h0c0e_0085, "late word");
        if (clear) begin
            pulse(C_CLR);
            pulse(C_ON);
            await(2, "late drop");
            chk(TX_HALTED, 1'b0, "late resume");
        end else begin
            pulse(C_ON);
            await(4, "late resend");
            finish_ok(32'h0c0e_0080);
        end
    endtask
    task automatic t_excess;
        start(20'h0_0b0d);
        await(4, "launch");
        repeat (16) pulse(C_COLL);
        await(2, "excess drop");
        chk(TX_HALTED, 1'b1, "excess halt");
        rd(TXLO_OFS_OUTCOME);
        chk(rdata, 32'h0b0d_0089, "excess word");
        pulse(C_ON);
        chk(TX_HALTED, 1'b0, "excess resume");
    endtask
    task automatic t_starve;
        start(20'h1_0d0f);
        await(4, "launch");
        pulse(C_STARVE);
        await(0, "fifo halt");
        chk(TX_HALTED, 1'b1, "tx halt");
        rd(TXLO_OFS_OUTCOME);
        chk(rdata, 32'h0d0f_00d1, "starve word");
        pulse(C_ON | C_REINIT);
        await(2, "starve drop");
        @(negedge CLK);
        chk({TX_HALTED, FIFO_HALTED}, 2'b00, "starve resume");
    endtask
    task automatic results;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Free-running 10 MHz clock
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    // Main sequence
    initial begin
        errors = 0;
        cmp_count = 0;
        RST = 1'b1;
        {REG_WR, REG_RD, REG_ADDR, REG_WDATA, FIFO_WORDS, FIFO_FRAME_LOADED} = '0;
        {coll_cmd, end_cmd, FIFO_STARVED, TRANSMITTER_ON_SET, TRANSMITTER_REINIT, FIFO_CLEAR, DESC_VALID} = 7'h00;
        DESC_CTRL = '0;
        repeat (20) @(negedge CLK);
        RST = 1'b0;
        t_regs;
        t_thresh;
        t_offload;
        t_late(1'b0);
        t_late(1'b1);
        t_excess;
        t_starve;
        results;
    end
    // Watchdog: the run needs about 8,400 cycles
    initial begin
        #3000000;
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        results;
    end
endmodule
`default_nettype wire
